// ==== hdl/lbs_ctrl.sv ====
`default_nettype none
module lbs_ctrl
  import lbs_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC,
  parameter logic [23:0] PAIR_CODE_INIT = PAIR_CODE_DEFAULT
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_b,
  // Button pin, high while pressed.
  input wire logic button_pin,
  // Radio state from the system.
  input wire logic bt_connected,
  input wire logic ap_en_at_boot,
  input wire logic bt_en_at_boot,
  // Indicator LEDs.
  output var lbs_leds_t ap_bt_leds,
  // Radio configuration and reset event.
  output var lbs_cfg_t radio_cfg,
  output logic boot_done
);

  localparam int unsigned TW = $clog2(TICK_CYCLES + 1);

  typedef struct packed {
    logic [TW-1:0] pre;
    logic tick;
    logic [15:0] ms;
    logic [15:0] blink_ms;
    logic slow_ph;
    logic fast_ph;
    logic [2:0] sync;
    logic [15:0] deb_ms;
    logic btn;
    logic [15:0] hold_ms;
    logic long_done;
    lbs_state_t st;
    logic boot_ap;
    logic boot_bt;
    logic radio_off;
    lbs_leds_t leds;
    lbs_cfg_t cfg;
    logic done;
  } lbs_regs_t;

  lbs_regs_t r_ff;
  lbs_regs_t nxt_r;

  function automatic logic [15:0] ms16(input int unsigned v);
    return v[15:0];
  endfunction : ms16

  always_comb begin
    nxt_r = r_ff;
    nxt_r.cfg.net_reset = 1'b0;
    // Shared millisecond timebase for every delay and blink.
    nxt_r.tick = 1'b0;
    if (r_ff.pre == TW'(TICK_CYCLES - 1)) begin
      nxt_r.pre = '0;
      nxt_r.tick = 1'b1;
    end else begin
      nxt_r.pre = r_ff.pre + TW'(1);
    end
    if (r_ff.tick) begin
      nxt_r.blink_ms = r_ff.blink_ms + 16'h0001;
      if (r_ff.blink_ms % ms16(FAST_HALF_MS) == 16'h0000) begin
        nxt_r.fast_ph = ~r_ff.fast_ph;
      end
      if (r_ff.blink_ms == ms16(SLOW_HALF_MS - 1)) begin
        nxt_r.blink_ms = '0;
        nxt_r.slow_ph = ~r_ff.slow_ph;
      end
    end
    // Three-stage synchroniser, then a debounce of a quiet interval.
    nxt_r.sync = {r_ff.sync[1:0], button_pin};
    if (r_ff.sync[2] == r_ff.btn) begin
      nxt_r.deb_ms = '0;
    end else if (r_ff.tick) begin
      nxt_r.deb_ms = r_ff.deb_ms + 16'h0001;
      if (r_ff.deb_ms == ms16(DEBOUNCE_MS - 1)) begin
        nxt_r.btn = r_ff.sync[2];
        nxt_r.deb_ms = '0;
      end
    end
    // Hold timer; releasing resets it, so the hold must be continuous.
    if (!r_ff.btn) begin
      nxt_r.hold_ms = '0;
      nxt_r.long_done = 1'b0;
    end else if (r_ff.tick && r_ff.hold_ms != ms16(LONG_MS)) begin
      nxt_r.hold_ms = r_ff.hold_ms + 16'h0001;
    end
    if (r_ff.tick) begin
      nxt_r.ms = r_ff.ms + 16'h0001;
    end
    case (r_ff.st)
      ST_DARK: begin
        nxt_r.leds = '0;
        if (r_ff.tick && r_ff.ms == ms16(DARK_MS - 1)) begin
          nxt_r.st = ST_RED;
          nxt_r.ms = '0;
        end
      end
      ST_RED: begin
        nxt_r.leds = '{ap_red: r_ff.slow_ph, default: 1'b0};
        if (r_ff.tick && r_ff.ms == ms16(RED_MS - 1)) begin
          nxt_r.st = ST_GREEN;
          nxt_r.ms = '0;
        end
      end
      ST_GREEN: begin
        nxt_r.leds = '{ap_green: r_ff.slow_ph & r_ff.boot_ap,
                       default: 1'b0};
        if (r_ff.tick && r_ff.ms == ms16(GREEN_MS - 1)) begin
          nxt_r.st = ST_RUN;
          nxt_r.ms = '0;
          nxt_r.done = 1'b1;
        end
      end
      ST_RUN: begin
        nxt_r.leds.ap_red = r_ff.slow_ph & ~r_ff.cfg.ap_en;
        nxt_r.leds.ap_green = r_ff.slow_ph & r_ff.cfg.ap_en;
        // Fourth boot stage and operation share the Bluetooth display.
        nxt_r.leds.bt_blue = r_ff.cfg.bt_en &
                             (bt_connected | r_ff.slow_ph);
        if (r_ff.btn && r_ff.tick && r_ff.hold_ms == ms16(LONG_MS - 1)) begin
          nxt_r.st = ST_SOLID;
          nxt_r.ms = '0;
          nxt_r.long_done = 1'b1;
          nxt_r.cfg.ap_en = AP_EN_DEFAULT;
          nxt_r.cfg.pair_code = PAIR_CODE_INIT;
          nxt_r.cfg.net_reset = 1'b1;
          nxt_r.radio_off = 1'b1;
        end else if (!r_ff.btn && nxt_r.btn == 1'b0 && r_ff.hold_ms != '0
                     && !r_ff.long_done) begin
          nxt_r.hold_ms = '0;
        end
      end
      ST_SOLID: begin
        nxt_r.leds = '{ap_red: 1'b0, ap_green: 1'b1, bt_blue: 1'b1};
        if (r_ff.tick && r_ff.ms == ms16(SOLID_MS - 1)) begin
          nxt_r.st = ST_FAST;
          nxt_r.ms = '0;
        end
      end
      ST_FAST: begin
        // Stays here until power is cycled.
        nxt_r.leds = '{ap_green: r_ff.fast_ph, default: 1'b0};
        nxt_r.ms = '0;
      end
      default: begin
        nxt_r.st = ST_DARK;
      end
    endcase
    // Short press: released before the long threshold.
    if (r_ff.st == ST_RUN && r_ff.btn && !nxt_r.btn && !r_ff.long_done
        && r_ff.hold_ms < ms16(LONG_MS)) begin
      nxt_r.cfg.ap_en = ~r_ff.cfg.ap_en;
      nxt_r.cfg.bt_en = ~r_ff.cfg.bt_en;
    end
    // Radios stay down after a factory reset until power cycle.
    if (r_ff.radio_off) begin
      nxt_r.cfg.bt_en = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      r_ff <= '0;
      r_ff.st <= ST_DARK;
      r_ff.cfg.pair_code <= PAIR_CODE_INIT;
      r_ff.boot_ap <= AP_EN_DEFAULT;
      r_ff.boot_bt <= BT_EN_DEFAULT;
      r_ff.cfg.ap_en <= AP_EN_DEFAULT;
      r_ff.cfg.bt_en <= BT_EN_DEFAULT;
    end else begin
      r_ff <= nxt_r;
      // Boot-time enables are caught during the dark stage.
      if (r_ff.st == ST_DARK) begin
        r_ff.boot_ap <= ap_en_at_boot;
        r_ff.boot_bt <= bt_en_at_boot;
        r_ff.cfg.ap_en <= ap_en_at_boot;
        r_ff.cfg.bt_en <= bt_en_at_boot;
      end
    end
  end

  always_comb begin
    ap_bt_leds = r_ff.leds;
    radio_cfg = r_ff.cfg;
    radio_cfg.ap_en = r_ff.cfg.ap_en & ~r_ff.radio_off;
    boot_done = r_ff.done;
  end

endmodule : lbs_ctrl
`default_nettype wire

// ==== inc/lbs_pkg.sv ====
`default_nettype none
package lbs_pkg;
  localparam int unsigned CLK_HZ = 250_000_000;
  // Times in milliseconds.
  localparam int unsigned DARK_MS = 4000;
  localparam int unsigned RED_MS = 40000;
  localparam int unsigned GREEN_MS = 10000;
  localparam int unsigned LONG_MS = 4000;
  localparam int unsigned SOLID_MS = 2000;
  localparam int unsigned DEBOUNCE_MS = 20;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  // Blink half periods in milliseconds.
  localparam int unsigned SLOW_HALF_MS = 500;
  localparam int unsigned FAST_HALF_MS = 100;
  localparam logic [23:0] PAIR_CODE_DEFAULT = 24'h000000;
  localparam logic AP_EN_DEFAULT = 1'b1;
  localparam logic BT_EN_DEFAULT = 1'b1;

  typedef enum {
    ST_DARK,
    ST_RED,
    ST_GREEN,
    ST_RUN,
    ST_SOLID,
    ST_FAST
  } lbs_state_t;

  typedef struct packed {
    logic ap_red;
    logic ap_green;
    logic bt_blue;
  } lbs_leds_t;

  typedef struct packed {
    logic ap_en;
    logic bt_en;
    logic [23:0] pair_code;
    logic net_reset;
  } lbs_cfg_t;
endpackage : lbs_pkg
`default_nettype wire

// ==== tb/lbs_button_model.sv ====
`default_nettype none
module lbs_button_model (
  // Clock and button contact.
  input wire logic core_clk,
  output var logic button_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  initial button_pin = 1'h0;
  // The contact bounces, then stays closed for n cycles.
  task press(input int n);
    repeat (3) begin
      @(posedge core_clk) button_pin <= 1'h1;
      @(posedge core_clk) button_pin <= 1'h0;
    end
    @(posedge core_clk) button_pin <= 1'h1;
    repeat (n) @(posedge core_clk);
    button_pin <= 1'h0;
  endtask : press
endmodule : lbs_button_model
`default_nettype wire

// ==== tb/lbs_ctrl_sva.sv ====
`default_nettype none
module lbs_ctrl_sva
  import lbs_pkg::*;
#(parameter int unsigned TICK_CYCLES = TICK_CYC) (
  // Watched ports.
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic button_pin,
  input wire logic bt_connected,
  input wire logic ap_en_at_boot,
  input wire logic bt_en_at_boot,
  input wire lbs_leds_t ap_bt_leds,
  input wire lbs_cfg_t radio_cfg,
  input wire logic boot_done
);
  localparam int DARK_C = DARK_MS * TICK_CYCLES - 8;
  localparam int RED_C = (DARK_MS + RED_MS) * TICK_CYCLES - 8;
  localparam int LONG_C = LONG_MS * TICK_CYCLES;
  logic [31:0] cyc_ff;
  logic [31:0] hold_ff;
  logic fac_ff;
  logic run;
  // Cycles since reset, button hold time and the factory state seen.
  always_ff @(posedge core_clk) begin
    cyc_ff <= !rst_b ? 32'h0 : cyc_ff + {31'h0, ~&cyc_ff};
    hold_ff <= (rst_b && button_pin) ? hold_ff + 32'h1 : 32'h0;
    fac_ff <= rst_b && (fac_ff || radio_cfg.net_reset);
  end
  assign run = boot_done && !fac_ff && !radio_cfg.net_reset;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_dark_off:
    assert property (cyc_ff < DARK_C |-> ap_bt_leds == 3'h0)
    else $error("LED lit in dark stage");
  a_boot_wait:
    assert property (cyc_ff < RED_C |-> !boot_done && !ap_bt_leds.ap_green)
    else $error("red stage cut short");
  a_ap_enabled:
    assert property ((run && radio_cfg.ap_en)[*3] |-> !ap_bt_leds.ap_red)
    else $error("red shown while enabled");
  a_bt_solid:
    assert property ((run && radio_cfg.bt_en && bt_connected)[*3]
      |-> ap_bt_leds.bt_blue) else $error("blue not solid");
  a_toggle_both:
    assert property (run && $past(boot_done) && $changed(radio_cfg.ap_en)
      |-> $changed(radio_cfg.bt_en)) else $error("enables split");
  a_long_hold:
    assert property (radio_cfg.net_reset |-> hold_ff >= LONG_C)
    else $error("long press too early");
  a_solid_show:
    assert property ($rose(radio_cfg.net_reset) |-> ##2
      (ap_bt_leds.ap_green && ap_bt_leds.bt_blue)[*8])
    else $error("no steady LEDs");
  a_fac_off:
    assert property (fac_ff |-> !radio_cfg.ap_en && !radio_cfg.bt_en
      && radio_cfg.pair_code == 24'h0) else $error("factory state wrong");
endmodule : lbs_ctrl_sva
bind lbs_ctrl lbs_ctrl_sva #(.TICK_CYCLES(TICK_CYCLES)) lbs_ctrl_sva_i (
  .core_clk(core_clk), .rst_b(rst_b), .button_pin(button_pin),
  .bt_connected(bt_connected), .ap_en_at_boot(ap_en_at_boot),
  .bt_en_at_boot(bt_en_at_boot), .ap_bt_leds(ap_bt_leds),
  .radio_cfg(radio_cfg), .boot_done(boot_done));
`default_nettype wire

// ==== tb/lbs_ctrl_test.sv ====
`default_nettype none
module lbs_ctrl_test
  import lbs_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'h0;
  logic rst_b = 1'h0;
  logic bt_connected = 1'h0;
  logic ap_boot = 1'h1;
  logic bt_boot = 1'h1;
  logic button_pin;
  lbs_leds_t ap_bt_leds;
  lbs_leds_t prev;
  lbs_cfg_t radio_cfg;
  logic boot_done;
  int bad_count = 0;
  int n_tests = 0;
  int nrc = 0;
  int rr, gr, br, rh, gh, bh;
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  lbs_ctrl #(.TICK_CYCLES(1)) lbs_ctrl_i (.core_clk(core_clk),
    .rst_b(rst_b), .button_pin(button_pin), .bt_connected(bt_connected),
    .ap_en_at_boot(ap_boot), .bt_en_at_boot(bt_boot),
    .ap_bt_leds(ap_bt_leds),
    .radio_cfg(radio_cfg), .boot_done(boot_done));
  lbs_button_model lbs_button_model_i (.core_clk(core_clk),
    .button_pin(button_pin));
  always @(posedge core_clk) begin
    #1 nrc += int'(radio_cfg.net_reset === 1'h1);
  end
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check
  // Counts LED rises and lit cycles over n cycles.
  task watch(input int n);
    {rr, gr, br, rh, gh, bh} = {6{32'h0}};
    repeat (n) begin
      prev = ap_bt_leds;
      @(posedge core_clk);
      #1;
      rr += int'(ap_bt_leds.ap_red & ~prev.ap_red);
      gr += int'(ap_bt_leds.ap_green & ~prev.ap_green);
      br += int'(ap_bt_leds.bt_blue & ~prev.bt_blue);
      rh += int'(ap_bt_leds.ap_red === 1'h1);
      gh += int'(ap_bt_leds.ap_green === 1'h1);
      bh += int'(ap_bt_leds.bt_blue === 1'h1);
    end
  endtask : watch
  task stop_test();
    $display("Counts: %0d checks, %0d mismatches", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    #480000;
    bad_count++;
    stop_test();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rst_b <= 1'h1;
    watch(3990);
    check(rh + gh + bh, 0);
    repeat (20) @(posedge core_clk);
    watch(39900);
    check(32'(rr > 37), 32'h1);
    check(gh, 32'h0);
    repeat (100) @(posedge core_clk);
    watch(9800);
    check(32'(gr > 7), 32'h1);
    check(rh, 32'h0);
    repeat (300) @(posedge core_clk);
    check(boot_done, 1);
    $display("Test boot ended.");
    watch(2000);
    check(32'(gr > 0), 32'h1);
    check(32'(br > 0), 32'h1);
    check(rh, 32'h0);
    @(posedge core_clk) bt_connected <= 1'h1;
    repeat (10) @(posedge core_clk);
    watch(1000);
    check(bh, 1000);
    $display("Test run ended.");
    lbs_button_model_i.press(200);
    repeat (40) @(posedge core_clk);
    check({radio_cfg.ap_en, radio_cfg.bt_en}, 0);
    watch(2000);
    check(32'(rr > 0), 32'h1);
    check(gh, 32'h0);
    check(bh, 32'h0);
    lbs_button_model_i.press(3900);
    repeat (40) @(posedge core_clk);
    check({radio_cfg.ap_en, radio_cfg.bt_en}, 32'h3);
    check(nrc, 32'h0);
    $display("Test short press ended.");
    fork
      lbs_button_model_i.press(8000);
      begin
        repeat (4100) @(posedge core_clk);
        watch(1800);
        check(gh + bh, 3600);
        repeat (200) @(posedge core_clk);
        watch(1800);
        check(gr > 7, 1);
      end
    join
    check(nrc, 1);
    check({radio_cfg.ap_en, radio_cfg.pair_code}, 0);
    lbs_button_model_i.press(200);
    repeat (40) @(posedge core_clk);
    check({radio_cfg.ap_en, radio_cfg.bt_en}, 0);
    $display("Test long press ended.");
    stop_test();
  end
endmodule : lbs_ctrl_test
`default_nettype wire
